// file: inc/rate_ctrl_pkg.sv
// Purpose: shared constants for the input sync and rate control block
// Assumes: 125 MHz system clock, AXI4-Lite register access
// Notes: rates are in kbit/s, phase steps are 32-bit accumulator increments
package rate_ctrl_pkg;

  // system clock
  localparam longint CLK_HZ = 125000000;
  localparam int ACC_W = 32;

  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // control register fields
  localparam int CTRL_SEL_LO_BIT = 0;
  localparam int CTRL_SEL_HI_BIT = 1;
  localparam int CTRL_MCLK_DIS_BIT = 2;
  localparam int CTRL_SAMPLE_CLOCK_OUT_EN_BIT = 3;
  localparam int CTRL_SYNC_PULSE_BIT = 4;

  // status register fields
  localparam int STAT_STATE_LSB = 0;    // 4 bits, one-hot sync state
  localparam int STAT_REQ_ACTIVE_BIT = 4;
  localparam int STAT_MUTED_BIT = 5;
  localparam int STAT_FS_LSB = 8;       // 2 bits
  localparam int STAT_RATE_LSB = 12;    // 4 bits

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // bit rate index after reset (384 kbit/s)
  localparam logic [3:0] RATE_IDX_RESET = 4'hE;

  // sample rate codes, 44.1 kHz after reset
  localparam logic [1:0] FS_44K1 = 2'h0;
  localparam logic [1:0] FS_48K = 2'h1;
  localparam logic [1:0] FS_32K = 2'h2;
  localparam logic [1:0] FS_RESET = FS_44K1;

  // minimum muted frames on a confirmed sync
  localparam logic [1:0] MUTE_NOCRC_FREE = 2'd2;
  localparam logic [1:0] MUTE_NOCRC_FIXED = 2'd1;
  localparam logic [1:0] MUTE_CRC_FREE = 2'd1;
  localparam logic [1:0] MUTE_CRC_FIXED = 2'd0;

  // generated sample clock is 256 times the sample rate
  localparam longint FS_MULT = 256;
  localparam longint FS_44K1_HZ = 44100;
  localparam longint FS_48K_HZ = 48000;
  localparam longint FS_32K_HZ = 32000;
  localparam logic [31:0] FS_STEP_44K1 = 32'(((FS_MULT * FS_44K1_HZ) << ACC_W) / CLK_HZ);
  localparam logic [31:0] FS_STEP_48K = 32'(((FS_MULT * FS_48K_HZ) << ACC_W) / CLK_HZ);
  localparam logic [31:0] FS_STEP_32K = 32'(((FS_MULT * FS_32K_HZ) << ACC_W) / CLK_HZ);

  // request step per kbit/s: per system clock, or per sample clock input edge
  // at an assumed 44.1 kHz for the 256x and 384x ratios
  localparam longint RATE_LOW_SR = 256;
  localparam longint RATE_HIGH_SR = 384;
  localparam logic [19:0] KBPS_STEP_CLK = 20'((64'd1000 << ACC_W) / CLK_HZ);
  localparam logic [19:0] KBPS_STEP_256 = 20'((64'd1000 << ACC_W) / (RATE_LOW_SR * FS_44K1_HZ));
  localparam logic [19:0] KBPS_STEP_384 = 20'((64'd1000 << ACC_W) / (RATE_HIGH_SR * FS_44K1_HZ));

  // bit rate index to kbit/s
  function automatic logic [8:0] rate_kbps(input logic [3:0] idx);
    logic [8:0] kbps;
    case (idx)
      4'h1: kbps = 9'd32;
      4'h2: kbps = 9'd48;
      4'h3: kbps = 9'd56;
      4'h4: kbps = 9'd64;
      4'h5: kbps = 9'd80;
      4'h6: kbps = 9'd96;
      4'h7: kbps = 9'd112;
      4'h8: kbps = 9'd128;
      4'h9: kbps = 9'd160;
      4'hA: kbps = 9'd192;
      4'hB: kbps = 9'd224;
      4'hC: kbps = 9'd256;
      4'hD: kbps = 9'd320;
      4'hE: kbps = 9'd384;
      default: kbps = 9'd0;
    endcase
    return kbps;
  endfunction : rate_kbps

  // sync search states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SEARCH = 4'b0010,
    ST_VERIFY = 4'b0100,
    ST_LOCKED = 4'b1000
  } sync_state_t;

endpackage : rate_ctrl_pkg

// file: src/rate_nco.sv
// Purpose: phase accumulator producing a tick and a square wave
// Assumes: step held steady by the caller between changes
// Notes: tick is a one-cycle pulse on each accumulator wrap
`timescale 1ns/10ps
module rate_nco
  import rate_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic advance,
  input wire logic [ACC_W-1:0] step,
  output logic tick,
  output logic phaseMsb
);

  logic [ACC_W-1:0] phase;
  logic [ACC_W:0] next_phase;

  assign next_phase = {1'b0, phase} + {1'b0, step};

  // accumulate only when the caller says so; wrap gives the tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= '0;
      tick <= 1'b0;
    end else if (advance) begin
      phase <= next_phase[ACC_W-1:0];
      tick <= next_phase[ACC_W];
    end else begin
      tick <= 1'b0;
    end
  end

  // registered msb so the clock output is glitch free
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phaseMsb <= 1'b0;
    end else begin
      phaseMsb <= phase[ACC_W-1];
    end
  end

endmodule : rate_nco

// file: src/input_sync_rate_control.sv
// Purpose: clock outputs, input sync search and master input request rate
// Assumes: clock pins and stop are asynchronous; parser events are on clk
// Notes: clock copies are sampled at 125 MHz, so they carry up to 1 cycle jitter
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module input_sync_rate_control
  import rate_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // clock pins and straps
  input wire logic master_clock_in,
  input wire logic sample_clock_in,
  input wire logic crystal_44k_clock_in,
  input wire logic rate_clock_source_select,
  input wire logic sample_clock_ratio_select,
  input wire logic master_clock_freq_select,
  input wire logic stopIn,
  // events from the bitstream parser
  input wire logic dataArriving,
  input wire logic syncPatternSeen,
  input wire logic syncPulseSeen,
  input wire logic frameDone,
  input wire logic frameBad,
  input wire logic crcActive,
  input wire logic freeFormat,
  input wire logic [3:0] decodedRateIdx,
  input wire logic [1:0] decodedFsCode,
  // outputs
  output logic masterClockOut,
  output logic masterClockOutOe,
  output logic sampleClockOut,
  output logic sampleClockOutOe,
  output logic muteOut,
  output logic syncModePulse,
  output logic masterRequestActive,
  output logic masterRequestStrobe,
  output logic [3:0] requestRateIdx
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] mclkSync;
  logic [2:0] fsclkSync;
  logic [1:0] xtalSync;
  logic [1:0] srcSelSync;
  logic [1:0] ratioSync;
  logic [1:0] freqSync;
  logic [1:0] stopSync;

  // two flops per pin; sample_clock_in gets a third for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mclkSync <= '0;
      fsclkSync <= '0;
      xtalSync <= '0;
      srcSelSync <= '0;
      ratioSync <= '0;
      freqSync <= '0;
      stopSync <= '0;
    end else begin
      mclkSync <= {mclkSync[0], master_clock_in};
      fsclkSync <= {fsclkSync[1:0], sample_clock_in};
      xtalSync <= {xtalSync[0], crystal_44k_clock_in};
      srcSelSync <= {srcSelSync[0], rate_clock_source_select};
      ratioSync <= {ratioSync[0], sample_clock_ratio_select};
      freqSync <= {freqSync[0], master_clock_freq_select};
      stopSync <= {stopSync[0], stopIn};
    end
  end

  logic fsclkRise;
  logic stopNow;
  logic srcExternal;

  assign fsclkRise = fsclkSync[1] & ~fsclkSync[2];
  assign stopNow = stopSync[1];
  assign srcExternal = srcSelSync[1];

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] ctrl;
  logic masterSelected;
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  sync_state_t syncState;
  logic [1:0] fsCode;

  // select 00 is master, 10 or 11 slave; 01 is left as master
  assign masterSelected = ~ctrl[CTRL_SEL_HI_BIT];

  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // address and data may arrive in either order; hold each until both are in
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (awHeld & wHeld) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (awHeld & wHeld) begin
        wHeld <= 1'b0;
      end
    end
  end

  // write commit and response; only the low byte of ctrl holds fields
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (awHeld & wHeld) begin
      s_axi_bvalid <= 1'b1;
      if (awAddr == CTRL_OFFSET) begin
        s_axi_bresp <= RESP_OKAY;
        if (wStrb[0]) begin
          ctrl <= {27'h000_0000, wData[4:0]};
        end
      end else if (awAddr == STATUS_OFFSET) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_DECERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read path; unmapped addresses answer decode error with zero data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      if (s_axi_araddr == CTRL_OFFSET) begin
        s_axi_rdata <= ctrl;
      end else if (s_axi_araddr == STATUS_OFFSET) begin
        s_axi_rdata[STAT_STATE_LSB +: 4] <= syncState;
        s_axi_rdata[STAT_REQ_ACTIVE_BIT] <= masterRequestActive;
        s_axi_rdata[STAT_MUTED_BIT] <= muteOut;
        s_axi_rdata[STAT_FS_LSB +: 2] <= fsCode;
        s_axi_rdata[STAT_RATE_LSB +: 4] <= requestRateIdx;
      end else begin
        s_axi_rresp <= RESP_DECERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync search and verification

  logic [1:0] muteNeed;
  logic [1:0] muteCount;
  logic syncMark;

  // sync mode picks which kind of mark the search accepts
  assign syncMark = ctrl[CTRL_SYNC_PULSE_BIT] ? syncPulseSeen : syncPatternSeen;
  assign syncModePulse = ctrl[CTRL_SYNC_PULSE_BIT];

  // muted frame count from crc and free format
  always_comb begin
    case ({crcActive, freeFormat})
      2'b01: muteNeed = MUTE_NOCRC_FREE;
      2'b00: muteNeed = MUTE_NOCRC_FIXED;
      2'b11: muteNeed = MUTE_CRC_FREE;
      default: muteNeed = MUTE_CRC_FIXED;
    endcase
  end

  logic confirmNow;

  // confirmation happens on a good frame once enough muted frames passed,
  // or straight away on the mark when none are needed
  assign confirmNow = (syncState == ST_SEARCH && syncMark && muteNeed == 2'd0) ||
                      (syncState == ST_VERIFY && frameDone && !frameBad &&
                       (muteCount + 2'd1) >= muteNeed);

  // stop forces the sync loss; the state stays muted until locked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncState <= ST_IDLE;
      muteCount <= '0;
    end else if (stopNow) begin
      syncState <= ST_IDLE;
      muteCount <= '0;
    end else begin
      case (syncState)
        ST_IDLE: begin
          if (dataArriving) begin
            syncState <= ST_SEARCH;
          end
        end
        ST_SEARCH: begin
          // the first mark is taken at once, so at most the partial frame
          // already under way is skipped
          muteCount <= '0;
          if (confirmNow) begin
            syncState <= ST_LOCKED;
          end else if (syncMark) begin
            syncState <= ST_VERIFY;
          end
        end
        ST_VERIFY: begin
          if (frameBad) begin
            syncState <= ST_SEARCH;
          end else if (confirmNow) begin
            syncState <= ST_LOCKED;
          end else if (frameDone) begin
            muteCount <= muteCount + 2'd1;
          end
        end
        ST_LOCKED: begin
          if (frameBad) begin
            syncState <= ST_SEARCH;
          end
        end
        default: begin
          syncState <= ST_IDLE;
        end
      endcase
    end
  end

  // audio stays muted until the lock is confirmed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      muteOut <= 1'b1;
    end else begin
      muteOut <= (syncState != ST_LOCKED) | stopNow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master input request rate

  // the rate index survives slave use, stop and sync loss; only a confirmed
  // sync with a new index changes it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      requestRateIdx <= RATE_IDX_RESET;
      fsCode <= FS_RESET;
    end else if (confirmNow && masterSelected) begin
      if (decodedRateIdx != requestRateIdx) begin
        requestRateIdx <= decodedRateIdx;
      end
      fsCode <= decodedFsCode;
    end else begin
      requestRateIdx <= requestRateIdx;
    end
  end

  // requests run only on the master input and while stop is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      masterRequestActive <= 1'b0;
    end else begin
      masterRequestActive <= masterSelected & ~stopNow;
    end
  end

  logic [19:0] kbpsStep;
  logic [ACC_W-1:0] reqStep;
  logic reqAdvance;

  // crystal source steps every clock; external source steps on each sample
  // clock edge, so the rate follows the real sample rate in proportion
  always_comb begin
    if (!srcExternal) begin
      kbpsStep = KBPS_STEP_CLK;
    end else if (ratioSync[1]) begin
      kbpsStep = KBPS_STEP_384;
    end else begin
      kbpsStep = KBPS_STEP_256;
    end
  end

  // before sync the last selected index drives the request speed
  assign reqStep = ACC_W'(rate_kbps(requestRateIdx)) * ACC_W'(kbpsStep);
  assign reqAdvance = masterRequestActive & (srcExternal ? fsclkRise : 1'b1);

  rate_nco requestNco (
    .clk(clk),
    .rst(rst),
    .advance(reqAdvance),
    .step(reqStep),
    .tick(masterRequestStrobe),
    .phaseMsb()
  );

  ////////////////////////////////////////////////////////////////////////////
  // buffered clock outputs

  logic [ACC_W-1:0] fsStep;
  logic fsGenerated;
  logic crystalMode;

  // crystal mode generates 256 fs from the remembered sample rate
  always_comb begin
    case (fsCode)
      FS_48K: fsStep = FS_STEP_48K;
      FS_32K: fsStep = FS_STEP_32K;
      default: fsStep = FS_STEP_44K1;
    endcase
  end

  assign crystalMode = masterSelected & ~srcExternal;

  rate_nco sampleNco (
    .clk(clk),
    .rst(rst),
    .advance(1'b1),
    .step(fsStep),
    .tick(),
    .phaseMsb(fsGenerated)
  );

  // master clock is a copy of its pin, enabled unless disabled by software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      masterClockOut <= 1'b0;
      masterClockOutOe <= 1'b1;
    end else begin
      masterClockOut <= mclkSync[1];
      masterClockOutOe <= ~ctrl[CTRL_MCLK_DIS_BIT];
    end
  end

  // sample clock: copy in slave and external modes, generated in crystal mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sampleClockOut <= 1'b0;
      sampleClockOutOe <= 1'b0;
    end else begin
      sampleClockOut <= crystalMode ? fsGenerated : fsclkSync[2];
      sampleClockOutOe <= ctrl[CTRL_SAMPLE_CLOCK_OUT_EN_BIT];
    end
  end

endmodule : input_sync_rate_control

// file: verif/coded_source.sv
// Purpose: coded data source on the master input, with parser event drive
// Assumes: one bit leaves the source for each request strobe
// Notes: sync marks and frame results are issued by the bench through tasks
`timescale 1ns/10ps
module coded_source (
  input wire logic clk,
  input wire logic rst,
  input wire logic masterRequestStrobe,
  output logic dataArriving,
  output logic syncPatternSeen = 1'b0,
  output logic syncPulseSeen = 1'b0,
  output logic frameDone = 1'b0,
  output logic frameBad = 1'b0,
  output logic crcActive = 1'b0,
  output logic freeFormat = 1'b0,
  output logic [3:0] decodedRateIdx = 4'h0,
  output logic [1:0] decodedFsCode = 2'h0
);
  int nBits;

  ////////////////////////////////////////////////////////////////////////////
  // bits only flow on request, so a stopped master sees no data at all
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      nBits <= 0;
      dataArriving <= 1'b0;
    end else if (masterRequestStrobe) begin
      nBits <= nBits + 1;
      dataArriving <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // header fields seen while frames are checked
  task setup(input logic crc, input logic free, input logic [3:0] idx);
    @(posedge clk);
    crcActive <= crc;
    freeFormat <= free;
    decodedRateIdx <= idx;
    decodedFsCode <= 2'h1;
  endtask : setup

  // one-cycle mark at an arbitrary point of the stream
  task mark(input logic pulse);
    @(posedge clk);
    syncPatternSeen <= !pulse;
    syncPulseSeen <= pulse;
    @(posedge clk);
    syncPatternSeen <= 1'b0;
    syncPulseSeen <= 1'b0;
  endtask : mark

  // one decoded frame, good or false
  task frame(input logic bad);
    @(posedge clk);
    frameDone <= !bad;
    frameBad <= bad;
    @(posedge clk);
    frameDone <= 1'b0;
    frameBad <= 1'b0;
  endtask : frame
endmodule : coded_source

// file: verif/rate_ctrl_sva.sv
// Purpose: port-level checks of clock copies, muting and request rate
// Assumes: clock pins reach the outputs through three or four flops
// Notes: helper counter masks the pipeline fill after each reset
`timescale 1ns/10ps
module rate_ctrl_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic master_clock_in,
  input wire logic sample_clock_in,
  input wire logic rate_clock_source_select,
  input wire logic stopIn,
  input wire logic syncPatternSeen,
  input wire logic syncPulseSeen,
  input wire logic frameDone,
  input wire logic [3:0] decodedRateIdx,
  input wire logic s_axi_bvalid,
  input wire logic masterClockOut,
  input wire logic masterClockOutOe,
  input wire logic sampleClockOut,
  input wire logic sampleClockOutOe,
  input wire logic muteOut,
  input wire logic masterRequestActive,
  input wire logic masterRequestStrobe,
  input wire logic [3:0] requestRateIdx
);
  logic [2:0] upCnt;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // cycles since reset, saturating; the copy checks wait for full pipes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) upCnt <= 3'h0;
    else if (upCnt != 3'h7) upCnt <= upCnt + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_mclk_copy: assert property (upCnt == 3'h7 && masterClockOutOe |->
    masterClockOut == $past(master_clock_in, 3)) else $error("master clock copy wrong");
  a_sample_clock_out_copy: assert property (upCnt == 3'h7 && sampleClockOutOe && $past(rate_clock_source_select, 3)
    |-> sampleClockOut == $past(sample_clock_in, 4)) else $error("sample clock copy wrong");
  a_sample_clock_out_enable: assert property ($rose(sampleClockOutOe) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("sample clock enabled without a write");
  a_unmute_cause: assert property ($fell(muteOut) |->
    $past(frameDone, 2) || $past(syncPatternSeen, 2) || $past(syncPulseSeen, 2)) else $error("unmute without sync");
  a_rate_held: assert property ($changed(requestRateIdx) |->
    $past(frameDone) || $past(syncPatternSeen) || $past(syncPulseSeen)) else $error("rate changed without sync");
  a_rate_decoded: assert property ($changed(requestRateIdx) |-> requestRateIdx == $past(decodedRateIdx))
    else $error("rate not the decoded one");
  a_stop_halts: assert property (stopIn [*4] |-> !masterRequestActive)
    else $error("requests continue while stopped");
  a_idle_quiet: assert property (!masterRequestActive [*3] |-> !masterRequestStrobe)
    else $error("strobe while requests are off");

  c_locked: cover property ($fell(muteOut));
  c_rate_switch: cover property ($changed(requestRateIdx));
  c_stop_cycle: cover property (stopIn [*4] ##1 !stopIn);
endmodule : rate_ctrl_sva

// file: verif/test_input_sync_rate_control.sv
// Purpose: self-checking bench for the sync and rate control block
// Assumes: straps change only together with a reset
// Notes: bit counts are taken from the source model over fixed spans
`timescale 1ns/10ps
module test_input_sync_rate_control
  import rate_ctrl_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic master_clock_in = 1'b0, sample_clock_in = 1'b0, crystal_44k_clock_in = 1'b0, stopIn = 1'b0;
  logic rate_clock_source_select = 1'b0, sample_clock_ratio_select = 1'b0, master_clock_freq_select = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, decodedFsCode, rsp;
  logic [31:0] s_axi_rdata, rdv;
  logic dataArriving, syncPatternSeen, syncPulseSeen, frameDone, frameBad, crcActive, freeFormat;
  logic [3:0] decodedRateIdx, requestRateIdx;
  logic masterClockOut, masterClockOutOe, sampleClockOut, sampleClockOutOe, muteOut, syncModePulse;
  logic masterRequestActive, masterRequestStrobe;
  int n_errors = 0, n_compared = 0, b0, need;

  ////////////////////////////////////////////////////////////////////////////
  // master and sample pin clocks are offset so their edges never meet a clk edge; crystal edges do
  always #4 clk = ~clk;
  initial begin
    #1;
    forever #20 master_clock_in = ~master_clock_in;
  end
  initial begin
    #2;
    forever #22 crystal_44k_clock_in = ~crystal_44k_clock_in;
  end
  // sample clock runs only where the application uses it
  initial begin
    #3;
    forever #44 sample_clock_in = rate_clock_source_select & ~sample_clock_in;
  end

  input_sync_rate_control i_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .master_clock_in,
    .sample_clock_in, .crystal_44k_clock_in, .rate_clock_source_select, .sample_clock_ratio_select,
    .master_clock_freq_select, .stopIn, .dataArriving, .syncPatternSeen, .syncPulseSeen, .frameDone, .frameBad,
    .crcActive, .freeFormat, .decodedRateIdx, .decodedFsCode, .masterClockOut, .masterClockOutOe, .sampleClockOut,
    .sampleClockOutOe, .muteOut, .syncModePulse, .masterRequestActive, .masterRequestStrobe, .requestRateIdx);

  coded_source i_src (.clk, .rst, .masterRequestStrobe, .dataArriving, .syncPatternSeen, .syncPulseSeen,
    .frameDone, .frameBad, .crcActive, .freeFormat, .decodedRateIdx, .decodedFsCode);

  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  // straps move only while reset is high
  task do_reset(input logic m1);
    @(posedge clk);
    rst <= 1'b1;
    rate_clock_source_select <= m1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  // address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, ka, kw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk);
      ka = s_axi_awvalid & s_axi_awready;
      kw = s_axi_wvalid & s_axi_wready;
      @(posedge clk);
      if (ka) s_axi_awvalid <= 1'b0;
      if (kw) s_axi_wvalid <= 1'b0;
      ta = ta | ka;
      tw = tw | kw;
    end
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'b0);
    // reset words, enables and an unmapped address
    rd(CTRL_OFFSET);
    chk(rdv, CTRL_RESET);
    rd(STATUS_OFFSET);
    chk(rdv, 32'h0000_E031);
    chk(masterClockOutOe, 1'b1);
    chk(sampleClockOutOe, 1'b0);
    rd(8'h08);
    chk(rsp, RESP_DECERR);
    wr(8'h08, 32'h0000_001F);
    chk(rsp, RESP_DECERR);
    // crystal source: 384 kbit/s at 125 MHz gives 30.72 bits in 10000 cycles
    b0 = i_src.nBits;
    repeat (10000) @(posedge clk);
    chk(i_src.nBits - b0 inside {[30:31]}, 1'b1);
    // all crc and free-format cases, pattern mode and pulse mode
    for (int k = 0; k < 4; k++) begin
      need = (k[1] ? 0 : 1) + k[0];
      do_reset(1'b0);
      wr(CTRL_OFFSET, 32'(k[0]) << CTRL_SYNC_PULSE_BIT);
      chk(syncModePulse, k[0]);
      i_src.setup(k[1], k[0], 4'h8 + 4'(k));
      while (dataArriving !== 1'b1) @(posedge clk);
      i_src.mark(!k[0]);
      rd(STATUS_OFFSET);
      chk(rdv[3:0], 4'h2);
      i_src.mark(k[0]);
      repeat (need) begin
        repeat (3) @(posedge clk);
        chk(muteOut, 1'b1);
        i_src.frame(1'b0);
      end
      repeat (3) @(posedge clk);
      chk(muteOut, 1'b0);
      chk(requestRateIdx, 4'h8 + 4'(k));
    end
    // sync lost when locked, then a false sync while verifying
    i_src.frame(1'b1);
    i_src.setup(1'b0, 1'b0, 4'h3);
    i_src.mark(1'b1);
    repeat (3) @(posedge clk);
    chk(muteOut, 1'b1);
    i_src.frame(1'b1);
    rd(STATUS_OFFSET);
    chk(rdv[3:0], 4'h2);
    chk(requestRateIdx, 4'hB);
    // stop halts requests and resumes at the kept rate
    stopIn <= 1'b1;
    repeat (5) @(posedge clk);
    chk(masterRequestActive, 1'b0);
    b0 = i_src.nBits;
    repeat (5000) @(posedge clk);
    chk(i_src.nBits - b0, 0);
    stopIn <= 1'b0;
    repeat (5) @(posedge clk);
    chk(masterRequestActive, 1'b1);
    // selects 11, 10, 01, 00 in turn
    for (int j = 3; j >= 0; j--) begin
      wr(CTRL_OFFSET, 32'(j));
      repeat (2) @(posedge clk);
      chk(masterRequestActive, !j[1]);
    end
    chk(requestRateIdx, 4'hB);
    // output enables follow the control word
    wr(CTRL_OFFSET, 32'h0000_000C);
    repeat (2) @(posedge clk);
    chk(masterClockOutOe, 1'b0);
    chk(sampleClockOutOe, 1'b1);
    // external 256x clock: 384 kbit/s at 44.1 kHz is 68.03 bits per 2000 edges
    do_reset(1'b1);
    wr(CTRL_OFFSET, 32'h0000_0008);
    b0 = i_src.nBits;
    repeat (22000) @(posedge clk);
    chk(i_src.nBits - b0 inside {[67:69]}, 1'b1);
    close_out;
  end

  // watchdog, well past the expected run of about 40000 cycles
  initial begin
    #600_000;
    n_errors++;
    close_out;
  end
endmodule : test_input_sync_rate_control

bind input_sync_rate_control rate_ctrl_sva i_sva (.clk, .rst, .master_clock_in, .sample_clock_in,
  .rate_clock_source_select, .stopIn, .syncPatternSeen, .syncPulseSeen, .frameDone, .decodedRateIdx, .s_axi_bvalid,
  .masterClockOut, .masterClockOutOe, .sampleClockOut, .sampleClockOutOe, .muteOut, .masterRequestActive,
  .masterRequestStrobe, .requestRateIdx);
